/* hdl/start_sequencer_pkg.sv */
// What this block does
// R1: restart sequence on power-up and wake
// R2: speed detect if enabled, else brake decision
// R3: slow motor is stationary, else direction check
// R4: forward resyncs to closed loop; reverse checks limit
// R5: reverse too fast returns to speed detect
// R6: reverse drive if enabled, else brake decision
// R7: reverse drive decelerates, zero speed to accelerate
// R8: nonzero brake time brakes with low sides
// R9: brake held for set time, then position decision
// R10: nonzero current threshold selects position detect
// R11: align drives V to W, then accelerate
// R12: position detect done leads to accelerate
// R13: open-loop ramp until rate passes handoff threshold
// R14: closed loop commutates from comparator feedback
// R15: direction change stops drive and restarts
// R16: phases floating during speed detection
// R17: comparator phase order gives direction
// R18: speed from successive comparator rising edges
// R19: no toggle within timeout means stationary
// R20: resync loads measured speed and position
// R21: reverse drive keeps accelerating through zero
// R22: six pulses, shortest time picks position
// R23: release mode chooses recirculate or float
// R24: phases float in power-on and decisions
// R25: configuration frozen when leaving power-on
package start_sequencer_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_TIME_NS  = 100000;
   localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int MS_TICKS      = 1000000 / TICK_TIME_NS;
   localparam int BRAKE_STEP_MS = 10;
   localparam int ALIGN_STEP_MS = 40;
   localparam int STILL_STEP_MS = 100;
   localparam int REV_BASE_MS   = 8;
   localparam logic [15:0] BRAKE_TICKS = 16'(BRAKE_STEP_MS * MS_TICKS);
   localparam logic [15:0] ALIGN_TICKS = 16'(ALIGN_STEP_MS * MS_TICKS);
   localparam logic [15:0] STILL_TICKS = 16'(STILL_STEP_MS * MS_TICKS);
   localparam logic [15:0] REV_TICKS   = 16'(REV_BASE_MS * MS_TICKS);
   localparam int DECAY_TIME_NS = 20000;
   localparam logic [12:0] DECAY_CYCLES = 13'(DECAY_TIME_NS / CLK_PERIOD_NS);
   localparam logic [12:0] PULSE_MAX    = 13'h0fff;
   localparam logic [15:0] RATE_FULL    = 16'h8000;
   localparam int RATE_SHIFT = 8;
   localparam logic [3:0] ADDR_CFG0 = 4'h0;
   localparam logic [3:0] ADDR_CFG1 = 4'h4;
   localparam logic [3:0] ADDR_STAT = 4'h8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] CFG0_RESET = 32'h0000_1001;
   localparam logic [31:0] CFG0_MASK  = 32'h003f_77f7;
   localparam logic [31:0] CFG1_RESET = 32'h0000_0811;
   localparam logic [31:0] CFG1_MASK  = 32'h0000_1f77;

   typedef enum logic [3:0] {
      sPowerOn, sSpeedEnJudge, sSpeedDetect, sSpeedJudge, sFwdJudge,
      sRevLimitJudge, sRevEnJudge, sReverseDrive, sBrakeJudge, sBrake,
      sPosEnJudge, sAlign, sPosDetect, sAccel, sClosedLoop
   } state_type;

   typedef struct packed {
      logic [9:0] rsvd3;
      logic [1:0] openLoopCurrent;
      logic [3:0] posDetThr;
      logic       rsvd2;
      logic [2:0] alignDuration;
      logic       rsvd1;
      logic [2:0] brakeDuration;
      logic [1:0] reverseLimit;
      logic [1:0] stationaryThr;
      logic       rsvd0;
      logic       releaseMode;
      logic       reverseDriveEnable;
      logic       speedDetectEnable;
   } cfg0_type;

   typedef struct packed {
      logic [18:0] rsvd2;
      logic [4:0]  handoffThr;
      logic        rsvd1;
      logic [2:0]  accel2;
      logic        rsvd0;
      logic [2:0]  accel1;
   } cfg1_type;

   typedef struct packed {
      logic [15:0] rate;
      logic [4:0]  rsvd;
      logic [2:0]  position;
      logic        reverseSeen;
      logic [2:0]  step;
      logic [3:0]  state;
   } status_type;

   typedef struct packed {
      logic [2:0] hi;
      logic [2:0] lo;
   } phase_type;

   function automatic phase_type pairDrive(input logic [1:0] h, input logic [1:0] l);
      phase_type p;
      p.hi = 3'h1 << h;
      p.lo = 3'h1 << l;
      return p;
   endfunction

   // six-step table, phase 0=U 1=V 2=W
   function automatic phase_type stepDrive(input logic [2:0] s);
      case (s)
         3'h0: return pairDrive(2'h0, 2'h1);
         3'h1: return pairDrive(2'h0, 2'h2);
         3'h2: return pairDrive(2'h1, 2'h2);
         3'h3: return pairDrive(2'h1, 2'h0);
         3'h4: return pairDrive(2'h2, 2'h0);
         default: return pairDrive(2'h2, 2'h1);
      endcase
   endfunction

   // pulse order VW WV UV VU WU UW mapped to steps
   function automatic logic [2:0] pulseStep(input logic [2:0] i);
      case (i)
         3'h0: return 3'h2;
         3'h1: return 3'h5;
         3'h2: return 3'h0;
         3'h3: return 3'h3;
         3'h4: return 3'h4;
         default: return 3'h1;
      endcase
   endfunction
endpackage

/* hdl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
   import start_sequencer_pkg::*;
#(
   parameter int W = 4
) (
   input  wire logic         clk,    // system clock
   input  wire logic         srst,   // sync reset
   input  wire logic [W-1:0] pinIn,  // raw pins
   output logic      [W-1:0] pinOut  // filtered levels
);
   logic [W-1:0] ff1_r;
   logic [W-1:0] ff2_r;
   logic [W-1:0] ff3_r;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : gBit
         always_ff @(posedge clk) begin
            if (srst) begin
               ff1_r[g]  <= 1'b0;
               ff2_r[g]  <= 1'b0;
               ff3_r[g]  <= 1'b0;
               pinOut[g] <= 1'b0;
            end else begin
               ff1_r[g] <= pinIn[g];
               ff2_r[g] <= ff1_r[g];
               ff3_r[g] <= ff2_r[g];
               if (ff2_r[g] == ff3_r[g]) begin
                  pinOut[g] <= ff3_r[g];
               end
            end
         end
      end
   endgenerate
endmodule // pin_sync
`default_nettype wire

/* hdl/tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module tick_gen
   import start_sequencer_pkg::*;
#(
   parameter int CYCLES = TICK_CYCLES
) (
   input  wire logic clk,   // system clock
   input  wire logic srst,  // sync reset
   output logic      tick   // one-cycle enable
);
   logic [31:0] cnt_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r <= 32'h0;
         tick  <= 1'b0;
      end else if (cnt_r == 32'(CYCLES - 1)) begin
         cnt_r <= 32'h0;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
         tick  <= 1'b0;
      end
   end
endmodule // tick_gen
`default_nettype wire

/* hdl/start_sequencer.sv */
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module start_sequencer
   import start_sequencer_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input  wire logic        clk,           // 200 MHz clock
   input  wire logic        srst,          // sync reset
   input  wire logic        wakeEvent,     // leaving standby/sleep
   input  wire logic        dirPin,        // direction pin
   input  wire logic        cmpUV,         // U-V comparator
   input  wire logic        cmpUW,         // U-W comparator
   input  wire logic        currentAtThr,  // pulse current reached
   output phase_type        drive,         // gate enables
   output logic [1:0]       currentSel,    // open-loop current
   input  wire logic [3:0]  awaddr,        // axi write addr
   input  wire logic        awvalid,       // axi
   output logic             awready,       // axi
   input  wire logic [31:0] wdata,         // axi
   input  wire logic [3:0]  wstrb,         // axi
   input  wire logic        wvalid,        // axi
   output logic             wready,        // axi
   output logic [1:0]       bresp,         // axi
   output logic             bvalid,        // axi
   input  wire logic        bready,        // axi
   input  wire logic [3:0]  araddr,        // axi read addr
   input  wire logic        arvalid,       // axi
   output logic             arready,       // axi
   output logic [31:0]      rdata,         // axi
   output logic [1:0]       rresp,         // axi
   output logic             rvalid,        // axi
   input  wire logic        rready         // axi
);
   logic [31:0] cfg0Reg_r;
   logic [31:0] cfg1Reg_r;
   cfg0_type    cfg0_r;
   cfg1_type    cfg1_r;
   state_type   st_r;
   state_type   stNxt;
   logic [3:0]  syncd;
   logic [1:0]  cmpPrev_r;
   logic [1:0]  rise;
   logic        cmpEdge;
   logic        dirPrev_r;
   logic        restart;
   logic        tick;
   logic [15:0] tmr_r;
   logic        edgeSeen_r;
   logic        periodDone_r;
   logic        dirKnown_r;
   logic        fwd_r;
   logic        still_r;
   logic [15:0] period_r;
   logic [2:0]  pdIdx_r;
   logic        pdDecay_r;
   logic [12:0] pdCnt_r;
   logic [12:0] best_r;
   logic [2:0]  bestIdx_r;
   logic        pdDone;
   logic        pulseEnd;
   logic [15:0] rate_r;
   logic [15:0] acc2_r;
   logic [15:0] phase_r;
   logic [2:0]  step_r;
   logic [16:0] phaseSum;
   logic [16:0] delta;
   status_type  stat;
   logic        wrGo;

   pin_sync #(.W(4)) i_pin_sync (
      .clk    (clk),
      .srst   (srst),
      .pinIn  ({currentAtThr, dirPin, cmpUW, cmpUV}),
      .pinOut (syncd)
   );

   tick_gen #(.CYCLES(TICK_LEN)) i_tick_gen (
      .clk  (clk),
      .srst (srst),
      .tick (tick)
   );

   function automatic logic [15:0] rateFromPeriod(input logic [15:0] p);
      logic [15:0] r;
      r = RATE_FULL;
      for (int i = 1; i < 16; i++) begin
         if (p >= (16'h1 << i)) begin
            r = RATE_FULL >> i;
         end
      end
      return r;
   endfunction

   function automatic logic [2:0] stepFromCmp(input logic uv, input logic uw);
      return {uv, uw, 1'b0} == 3'h0 ? 3'h0 : (uv ? (uw ? 3'h2 : 3'h1) : 3'h4);
   endfunction

   assign rise     = syncd[1:0] & ~cmpPrev_r;
   assign cmpEdge  = |(syncd[1:0] ^ cmpPrev_r);
   assign restart  = wakeEvent || (syncd[2] != dirPrev_r);
   assign pulseEnd = !pdDecay_r && (syncd[3] || pdCnt_r == PULSE_MAX);
   assign pdDone   = pdDecay_r && pdCnt_r == DECAY_CYCLES - 13'h1 && pdIdx_r == 3'h5;

   always_ff @(posedge clk) begin
      if (srst) begin
         cmpPrev_r <= 2'h0;
         dirPrev_r <= 1'b0;
      end else begin
         cmpPrev_r <= syncd[1:0];
         dirPrev_r <= syncd[2];
      end
   end

   // sequencing
   always_comb begin
      stNxt = st_r;
      case (st_r)
         sPowerOn:      stNxt = sSpeedEnJudge;
         sSpeedEnJudge: stNxt = cfg0_r.speedDetectEnable ? sSpeedDetect : sBrakeJudge; // R2
         sSpeedDetect: begin
            if (still_r || (periodDone_r && dirKnown_r)) begin
               stNxt = sSpeedJudge;
            end
         end
         sSpeedJudge: begin
            if (still_r || period_r >= STILL_TICKS * (cfg0_r.stationaryThr + 16'h1)) begin
               stNxt = sBrakeJudge; // R3
            end else begin
               stNxt = sFwdJudge; // R3
            end
         end
         sFwdJudge:      stNxt = fwd_r ? sClosedLoop : sRevLimitJudge; // R4
         sRevLimitJudge: begin
            if (period_r < (REV_TICKS >> cfg0_r.reverseLimit)) begin
               stNxt = sSpeedDetect; // R5
            end else begin
               stNxt = sRevEnJudge; // R5
            end
         end
         sRevEnJudge:   stNxt = cfg0_r.reverseDriveEnable ? sReverseDrive : sBrakeJudge; // R6
         sReverseDrive: begin
            if (rate_r == 16'h0) begin
               stNxt = sAccel; // R7 R21
            end
         end
         sBrakeJudge:   stNxt = (cfg0_r.brakeDuration != 3'h0) ? sBrake : sPosEnJudge; // R8
         sBrake: begin
            if (tmr_r >= BRAKE_TICKS * cfg0_r.brakeDuration) begin
               stNxt = sPosEnJudge; // R9
            end
         end
         sPosEnJudge:   stNxt = (cfg0_r.posDetThr != 4'h0) ? sPosDetect : sAlign; // R10
         sAlign: begin
            if (tmr_r >= ALIGN_TICKS * (cfg0_r.alignDuration + 16'h1)) begin
               stNxt = sAccel; // R11
            end
         end
         sPosDetect: begin
            if (pdDone) begin
               stNxt = sAccel; // R12
            end
         end
         sAccel: begin
            if (rate_r > {3'h0, cfg1_r.handoffThr, 8'h0}) begin
               stNxt = sClosedLoop; // R13
            end
         end
         sClosedLoop:   stNxt = sClosedLoop;
         default:       stNxt = sPowerOn;
      endcase
      if (restart) begin
         stNxt = sPowerOn; // R1 R15
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= sPowerOn; // R1
      end else begin
         st_r <= stNxt;
      end
   end

   // config snapshot per start attempt
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg0_r <= cfg0_type'(CFG0_RESET);
         cfg1_r <= cfg1_type'(CFG1_RESET);
      end else if (st_r == sPowerOn) begin
         cfg0_r <= cfg0_type'(cfg0Reg_r); // R25
         cfg1_r <= cfg1_type'(cfg1Reg_r); // R25
      end
   end

   // state timer in ticks; speed detect restarts it per rising edge
   always_ff @(posedge clk) begin
      if (srst || stNxt != st_r || (st_r == sSpeedDetect && |rise)) begin
         tmr_r <= 16'h0;
      end else if (tick && tmr_r != 16'hffff) begin
         tmr_r <= tmr_r + 16'h1;
      end
   end

   // speed and direction measurement
   always_ff @(posedge clk) begin
      if (srst || st_r != sSpeedDetect) begin
         edgeSeen_r   <= 1'b0;
         periodDone_r <= 1'b0;
         dirKnown_r   <= 1'b0;
         still_r      <= 1'b0;
         if (srst) begin
            fwd_r    <= 1'b1;
            period_r <= 16'h0;
         end
      end else begin
         if (|rise) begin
            edgeSeen_r <= 1'b1;
            if (edgeSeen_r) begin
               period_r     <= tmr_r; // R18
               periodDone_r <= 1'b1;
            end
         end
         if (rise[0]) begin
            fwd_r      <= !syncd[1]; // R17
            dirKnown_r <= 1'b1;
         end
         if (!(|rise) && tmr_r >= STILL_TICKS * (cfg0_r.stationaryThr + 16'h1)) begin
            still_r <= 1'b1; // R19
         end
      end
   end

   // position detect pulses
   always_ff @(posedge clk) begin
      if (srst || st_r != sPosDetect) begin
         pdIdx_r   <= 3'h0;
         pdDecay_r <= 1'b0;
         pdCnt_r   <= 13'h0;
         best_r    <= PULSE_MAX;
         bestIdx_r <= 3'h0;
      end else if (pulseEnd) begin
         pdDecay_r <= 1'b1;
         pdCnt_r   <= 13'h0;
         if (pdCnt_r < best_r) begin
            best_r    <= pdCnt_r; // R22
            bestIdx_r <= pdIdx_r; // R22
         end
      end else if (pdDecay_r && pdCnt_r == DECAY_CYCLES - 13'h1) begin
         pdDecay_r <= 1'b0;
         pdCnt_r   <= 13'h0;
         pdIdx_r   <= pdIdx_r + 3'h1; // R22
      end else begin
         pdCnt_r <= pdCnt_r + 13'h1;
      end
   end

   // drive rate, commutation step
   assign delta    = {14'h0, cfg1_r.accel1} + {9'h0, acc2_r[15:RATE_SHIFT]};
   assign phaseSum = {1'b0, phase_r} + {1'b0, rate_r};

   always_ff @(posedge clk) begin
      if (srst || st_r == sPowerOn) begin
         rate_r  <= 16'h0;
         acc2_r  <= 16'h0;
         phase_r <= 16'h0;
         step_r  <= 3'h0;
      end else if (stNxt != st_r) begin
         acc2_r  <= 16'h0;
         phase_r <= 16'h0;
         case (stNxt)
            sClosedLoop: begin
               if (st_r == sFwdJudge) begin
                  rate_r <= rateFromPeriod(period_r); // R20
                  step_r <= stepFromCmp(syncd[0], syncd[1]); // R20
               end
            end
            sReverseDrive: rate_r <= rateFromPeriod(period_r);
            sAccel: begin
               rate_r <= 16'h0;
               if (st_r == sAlign) begin
                  step_r <= 3'h2;
               end else if (st_r == sPosDetect) begin
                  step_r <= pulseStep(bestIdx_r); // R22
               end
            end
            default: rate_r <= rate_r;
         endcase
      end else if (st_r == sClosedLoop) begin
         if (cmpEdge) begin
            step_r <= (step_r == 3'h5) ? 3'h0 : step_r + 3'h1; // R14
         end
      end else if (tick && (st_r == sAccel || st_r == sReverseDrive)) begin
         acc2_r  <= acc2_r + {13'h0, cfg1_r.accel2}; // R13
         phase_r <= phaseSum[15:0];
         if (phaseSum[16]) begin
            step_r <= (step_r == 3'h5) ? 3'h0 : step_r + 3'h1;
         end
         if (st_r == sAccel) begin
            rate_r <= ({1'b0, rate_r} + delta > 17'hffff) ? 16'hffff : rate_r + delta[15:0]; // R13
         end else begin
            rate_r <= ({1'b0, rate_r} > delta) ? rate_r - delta[15:0] : 16'h0; // R7 R21
         end
      end
   end

   // gate outputs
   always_ff @(posedge clk) begin
      if (srst) begin
         drive      <= '0;
         currentSel <= 2'h0;
      end else begin
         currentSel <= 2'h0;
         case (stNxt)
            sBrake: drive <= '{hi: 3'h0, lo: 3'h7}; // R8
            sAlign: begin
               drive      <= pairDrive(2'h1, 2'h2); // R11
               currentSel <= cfg0_r.openLoopCurrent; // R11
            end
            sPosDetect: begin
               if (!pdDecay_r && !pulseEnd) begin
                  drive <= stepDrive(pulseStep(pdIdx_r)); // R22
               end else if (!cfg0_r.releaseMode) begin
                  drive <= phase_type'(stepDrive(pulseStep(pdIdx_r)) & 6'h07); // R23
               end else begin
                  drive <= '0; // R23
               end
            end
            sReverseDrive, sAccel: begin
               drive      <= stepDrive(step_r); // R7
               currentSel <= cfg0_r.openLoopCurrent;
            end
            sClosedLoop: drive <= stepDrive(step_r); // R14
            default: drive <= '0; // R16 R24 R15
         endcase
      end
   end

   // axi4-lite slave
   assign stat    = '{rate: rate_r, rsvd: 5'h0, position: bestIdx_r,
                      reverseSeen: !fwd_r, step: step_r, state: st_r};
   assign wrGo    = awvalid && wvalid && !bvalid;
   assign awready = wrGo;
   assign wready  = wrGo;
   assign arready = !rvalid;

   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] mask);
      logic [31:0] v;
      v = old;
      for (int b = 0; b < 4; b++) begin
         if (wstrb[b]) begin
            v[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      return v & mask;
   endfunction

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg0Reg_r <= CFG0_RESET;
         cfg1Reg_r <= CFG1_RESET;
         bvalid    <= 1'b0;
         bresp     <= RESP_OKAY;
      end else if (wrGo) begin
         bvalid <= 1'b1;
         bresp  <= RESP_OKAY;
         case (awaddr)
            ADDR_CFG0: cfg0Reg_r <= mergeBytes(cfg0Reg_r, CFG0_MASK);
            ADDR_CFG1: cfg1Reg_r <= mergeBytes(cfg1Reg_r, CFG1_MASK);
            ADDR_STAT: bresp <= RESP_OKAY;
            default:   bresp <= RESP_SLVERR;
         endcase
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0;
         rresp  <= RESP_OKAY;
      end else if (arvalid && !rvalid) begin
         rvalid <= 1'b1;
         rresp  <= RESP_OKAY;
         case (araddr)
            ADDR_CFG0: rdata <= cfg0Reg_r;
            ADDR_CFG1: rdata <= cfg1Reg_r;
            ADDR_STAT: rdata <= stat;
            default: begin
               rdata <= 32'h0;
               rresp <= RESP_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule // start_sequencer
`default_nettype wire

/* tb/start_sequencer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module start_sequencer_assertions
   import start_sequencer_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input wire logic        clk,        // clock
   input wire logic        srst,       // sync reset
   input wire logic        wakeEvent,  // wake request
   input wire logic        dirPin,     // direction pin
   input wire phase_type   drive,      // gate enables
   input wire logic [1:0]  currentSel, // current code
   input wire logic        awvalid,    // axi
   input wire logic        wvalid,     // axi
   input wire logic        bvalid,     // axi
   input wire logic        bready,     // axi
   input wire logic [1:0]  bresp,      // axi
   input wire logic        arvalid,    // axi
   input wire logic        rvalid,     // axi
   input wire logic        rready,     // axi
   input wire logic [31:0] rdata       // axi
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_reset_quiet: assert property (disable iff (1'b0) srst |=>
      drive == 6'h00 && currentSel == 2'h0 && !bvalid && !rvalid) else $error("outputs live after reset");
   a_wake_floats: assert property (wakeEvent |=> drive == 6'h00)
      else $error("drive active after wake");
   a_dir_stops: assert property ($changed(dirPin) |-> ##[1:6] drive == 6'h00)
      else $error("drive kept after direction change");
   a_brake_lowside: assert property (drive.lo == 3'h7 |-> drive.hi == 3'h0 && currentSel == 2'h0)
      else $error("brake with high side on");
   a_write_answer: assert property (awvalid && wvalid && !bvalid |=> bvalid)
      else $error("write not answered");
   a_read_answer: assert property (arvalid && !rvalid |=> rvalid)
      else $error("read not answered");
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
endmodule // start_sequencer_assertions

bind start_sequencer start_sequencer_assertions #(.TICK_LEN(TICK_LEN)) i_start_sequencer_assertions (
   .clk, .srst, .wakeEvent, .dirPin, .drive, .currentSel, .awvalid, .wvalid, .bvalid, .bready, .bresp,
   .arvalid, .rvalid, .rready, .rdata);
`default_nettype wire

/* tb/motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_model
   import start_sequencer_pkg::*;
#(
   parameter int HALF = 3000
) (
   input  wire logic       clk,          // clock
   input  wire logic [1:0] mode,         // 0 still, 1 forward, 2 reverse
   input  wire phase_type  drive,        // gate enables
   output logic            cmpUV,        // U-V comparator
   output logic            cmpUW,        // U-W comparator
   output logic            currentAtThr  // pulse current reached
);
   localparam int SIXTH = HALF / 3;
   int ph = 0;
   int onCnt = 0;
   always_ff @(posedge clk) begin
      ph <= (ph >= 2 * HALF - 1) ? 0 : ph + 1;
      onCnt <= (drive.hi != 3'h0) ? onCnt + 1 : 0;
   end
   // uw lags uv by 60 deg forward, leads it in reverse
   always_comb begin
      cmpUV = (mode != 2'h0) && (ph < HALF);
      if (mode == 2'h1) begin
         cmpUW = ph >= SIXTH && ph < HALF + SIXTH;
      end else begin
         cmpUW = (mode == 2'h2) && (ph >= 2 * HALF - SIXTH || ph < HALF - SIXTH);
      end
   end
   // winding current builds while a pair is energised
   assign currentAtThr = onCnt > 50;
endmodule // motor_model
`default_nettype wire

/* tb/start_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module start_sequencer_tb
   import start_sequencer_pkg::*;
;
   logic        clk, srst, wakeEvent, dirPin, currentAtThr, cmpUV, cmpUW, braked;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0]  mode, currentSel, bresp, rresp, rsp;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd;
   phase_type   drive;
   int          fails = 0, samplesChecked = 0, n;
   time         t0;

   start_sequencer #(.TICK_LEN(20)) i_start_sequencer (.clk, .srst, .wakeEvent, .dirPin, .cmpUV, .cmpUW,
      .currentAtThr, .drive, .currentSel, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   motor_model #(.HALF(3000)) i_motor_model (.clk, .mode, .drive, .cmpUV, .cmpUW, .currentAtThr);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) if (drive.lo === 3'h7) braked <= 1'b1;

   task report_and_stop();
      $display("checks %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task hang();
      fails++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop();
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      int k;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      k = 0;
      do begin @(posedge clk); k++; end while (!(awready && wready) && k < 50);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (!bvalid && k < 50) begin @(posedge clk); k++; end
      bready <= 1'b1;
      @(posedge clk);
      bready <= 1'b0;
      if (k >= 50) hang();
      check(32'(bresp), 32'(r));
   endtask
   task rdw(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      k = 0;
      do begin @(posedge clk); k++; end while (!arready && k < 50);
      arvalid <= 1'b0;
      while (!rvalid && k < 50) begin @(posedge clk); k++; end
      rready <= 1'b1;
      @(posedge clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (k >= 50) hang();
   endtask
   // waits for drive to reach p, or to leave it when leave is set
   task waitDrive(input logic [5:0] p, input int lim, input bit leave);
      n = 0;
      while (((drive !== p) ^ leave) && n < lim) begin @(posedge clk); n++; end
      if (n >= lim) hang();
   endtask
   task waitState(input logic [15:0] ok, input int lim);
      int k;
      k = 0;
      do begin rdw(ADDR_STAT, rd, rsp); k++; end while (!ok[rd[3:0]] && k < lim);
      if (k >= lim) hang();
   endtask
   task wake(input logic [31:0] cfg);
      wr(ADDR_CFG0, cfg, RESP_OKAY);
      braked = 1'b0;
      wakeEvent <= 1'b1;
      @(posedge clk);
      wakeEvent <= 1'b0;
   endtask

   initial begin
      {srst, wakeEvent, dirPin, mode, awvalid, wvalid, bready, arvalid, rready, braked} = 11'h400;
      {awaddr, araddr, wstrb, wdata} = '0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      rdw(ADDR_CFG0, rd, rsp);
      check(rd, CFG0_RESET);
      rdw(ADDR_CFG1, rd, rsp);
      check(rd, CFG1_RESET);
      rdw(4'hc, rd, rsp);
      check({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
      wr(4'hc, 32'hffff_ffff, RESP_SLVERR);
      wr(ADDR_STAT, 32'hffff_ffff, RESP_OKAY);
      wr(ADDR_CFG0, 32'hffff_ffff, RESP_OKAY);
      rdw(ADDR_CFG0, rd, rsp);
      check(rd, CFG0_MASK);
      // still motor: timeout, brake, align, ramp
      wr(ADDR_CFG1, 32'h0000_0177, RESP_OKAY);
      wake(32'h0020_0101);
      waitDrive(6'h07, 30000, 1'b0);
      check(32'(n > 19900 && n < 20100), 32'h1);
      waitDrive(6'h14, 3000, 1'b0);
      check(32'(n > 1900 && n < 2100), 32'h1);
      @(posedge clk);
      check(32'(currentSel), 32'h2);
      t0 = $time;
      waitState(16'h6000, 3000);
      check(32'(($time - t0) / CLK_PERIOD_NS > 7900 && ($time - t0) / CLK_PERIOD_NS < 8100), 32'h1);
      waitState(16'h4000, 20000);
      // detection off, position detect pulses
      wake(32'h0021_0000);
      waitDrive(6'h22, 6000, 1'b0);
      waitState(16'h4000, 20000);
      check(32'(braked), 32'h0);
      // forward spin resyncs
      mode <= 2'h1;
      wake(32'h0020_0101);
      waitState(16'h4000, 20000);
      check(32'(braked), 32'h0);
      // reverse spin with reverse drive enabled
      mode <= 2'h2;
      wake(32'h0020_01c3);
      waitState(16'he080, 20000);
      check({31'h0, rd[7]}, 32'h1);
      check(32'(braked), 32'h0);
      dirPin <= 1'b1;
      @(posedge clk);
      waitDrive(6'h00, 8, 1'b0);
      report_and_stop();
   end
endmodule // start_sequencer_tb
`default_nettype wire
